// file: rxpg_paging.sv
// Summary of operation
// - Paged addresses go to selected port blocks
// - Bit 4 picks the port supplying reads
// - Bits 1:0 enable writes per port block
// - Each access source keeps its own page state
// - Local source read select resets to port 0
// - Back-channel read select defaults to own port
// - Back-channel write enable set for own port
// - Bit 6 reports the carrying physical port
// - Enable 00 forwards raw video type always
// - Enable 1..3 tags first packets as embedded
// - Substitution ignored in CSI receive mode
// - Six-bit embedded code, reset 0x12, replaces type
`timescale 1ns/10ps

module rxpg_paging
   import rxpg_pkg::*;
(
   input  wire logic            clock,
   input  wire logic            resetn,
   input  wire rxpg_req_t       req,
   output logic                 rdValid_r,
   output logic [7:0]           rdData_r,
   output logic [NUM_PORTS-1:0] pagedWrEn,
   input  wire logic [7:0]      pagedRdata [NUM_PORTS],
   input  wire rxpg_pkt_t       pktIn      [NUM_PORTS],
   output rxpg_dt_t             dtOut      [NUM_PORTS],
   output logic [7:0]           embedCtrl  [NUM_PORTS]
);

   if (NUM_PORTS != 2 || NUM_SRC != 3) begin : g_cfg_check
      $error("Paging logic serves exactly two ports, three sources");
   end

   function automatic logic isPaged(input logic [7:0] a);
      isPaged = (a == ADDR_CAP) || (a == ADDR_EMBED)
             || (a >= PAGE_A_LO && a <= PAGE_A_HI)
             || (a >= PAGE_B_LO && a <= PAGE_B_HI);
   endfunction : isPaged

   // Default read port for a source: its own port over back channel
   function automatic logic srcPort(input int s);
      srcPort = (s == int'(SRC_BCC1));
   endfunction : srcPort

   function automatic logic [1:0] srcWrDefault(input int s);
      if (s == int'(SRC_BCC0))
         srcWrDefault = 2'h1;
      else if (s == int'(SRC_BCC1))
         srcWrDefault = 2'h2;
      else
         srcWrDefault = WR_NONE;
   endfunction : srcWrDefault

   logic       rdSel_r [NUM_SRC];
   logic [1:0] wrEn_r  [NUM_SRC];
   logic [7:0] embCtrl_r [NUM_PORTS];
   logic       firstCycle_r;

   logic       srcValid;
   logic       curRdSel;
   logic [1:0] curWrEn;
   logic       curPhys;
   logic       pagedHit;
   logic [7:0] selData;
   logic [7:0] selReg;
   logic [7:0] readNxt;

   assign srcValid = (req.src == SRC_LOCAL) || (req.src == SRC_BCC0)
                  || (req.src == SRC_BCC1);
   // Unknown source codes fall back to the local page copy
   assign curRdSel = srcValid ? rdSel_r[req.src] : rdSel_r[SRC_LOCAL];
   assign curWrEn  = srcValid ? wrEn_r[req.src]  : wrEn_r[SRC_LOCAL];
   assign curPhys  = (req.src == SRC_BCC1);
   assign pagedHit = isPaged(req.addr);

   // Port registers owned here answer locally; the rest come from outside
   always_comb begin
      if (req.addr == ADDR_EMBED)
         selData = embCtrl_r[curRdSel];
      else
         selData = pagedRdata[curRdSel];
   end

   always_comb begin
      selReg = READ_ZERO;
      selReg[SEL_PHYS_BIT] = curPhys;
      selReg[SEL_RD_BIT]   = curRdSel;
      selReg[SEL_WR1_BIT]  = curWrEn[1];
      selReg[SEL_WR0_BIT]  = curWrEn[0];
   end

   always_comb begin
      if (req.addr == ADDR_PORT_SEL)
         readNxt = selReg;
      else if (pagedHit)
         readNxt = selData;
      else
         readNxt = READ_ZERO;
   end

   always_comb begin
      pagedWrEn = '0;
      // Owned register is not echoed to the external port blocks
      if (req.wr && pagedHit && req.addr != ADDR_EMBED)
         pagedWrEn = curWrEn;
   end

   // Page state: one copy per source, only the requester's copy moves
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         for (int s = 0; s < NUM_SRC; s++) begin
            rdSel_r[s] <= srcPort(s);
            wrEn_r[s]  <= srcWrDefault(s);
         end
      end else if (req.wr && srcValid && req.addr == ADDR_PORT_SEL) begin
         rdSel_r[req.src] <= req.wdata[SEL_RD_BIT];
         wrEn_r[req.src]  <= req.wdata[SEL_WR1_BIT:SEL_WR0_BIT];
      end
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         for (int p = 0; p < NUM_PORTS; p++)
            embCtrl_r[p] <= EMB_RESET;
      end else if (req.wr && req.addr == ADDR_EMBED) begin
         for (int p = 0; p < NUM_PORTS; p++)
            if (curWrEn[p])
               embCtrl_r[p] <= req.wdata;
      end
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         rdValid_r <= 1'b0;
         rdData_r  <= READ_ZERO;
      end else begin
         rdValid_r <= req.rd;
         if (req.rd)
            rdData_r <= readNxt;
      end
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn)
         firstCycle_r <= 1'b1;
      else
         firstCycle_r <= 1'b0;
   end

   always_comb begin
      for (int p = 0; p < NUM_PORTS; p++)
         embedCtrl[p] = embCtrl_r[p];
   end

   for (genvar g = 0; g < NUM_PORTS; g++) begin : g_port
      rxpg_embed_sub u_embed (
         .clock  (clock),
         .resetn (resetn),
         .ctrl   (embCtrl_r[g]),
         .pkt    (pktIn[g]),
         .dtOut  (dtOut[g])
      );
   end

   property p_unpaged_ignored;
      @(posedge clock) disable iff (!resetn)
      req.wr && !isPaged(req.addr) |-> pagedWrEn == '0;
   endproperty
   a_unpaged_ignored: assert property (p_unpaged_ignored)
      else $error("Write outside paged range reached a port block");

   property p_read_port;
      @(posedge clock) disable iff (!resetn)
      req.rd && pagedHit && req.addr != ADDR_EMBED |=>
         rdValid_r && rdData_r == ($past(curRdSel) ? $past(pagedRdata[1])
                                                   : $past(pagedRdata[0]));
   endproperty
   a_read_port: assert property (p_read_port)
      else $error("Paged read answered by wrong port");

   property p_write_mask;
      @(posedge clock) disable iff (!resetn)
      req.wr && req.addr == ADDR_EMBED && !curWrEn[0] |=>
         $stable(embCtrl_r[0]);
   endproperty
   a_write_mask: assert property (p_write_mask)
      else $error("Disabled port 0 block took a write");

   property p_source_isolation;
      @(posedge clock) disable iff (!resetn)
      req.wr && req.addr == ADDR_PORT_SEL && req.src == SRC_LOCAL |=>
         $stable(rdSel_r[SRC_BCC0]) && $stable(wrEn_r[SRC_BCC0])
         && $stable(rdSel_r[SRC_BCC1]) && $stable(wrEn_r[SRC_BCC1]);
   endproperty
   a_source_isolation: assert property (p_source_isolation)
      else $error("Local page write disturbed a back-channel copy");

   property p_local_default;
      @(posedge clock) disable iff (!resetn)
      firstCycle_r |-> rdSel_r[SRC_LOCAL] == 1'b0
                       && wrEn_r[SRC_LOCAL] == WR_NONE;
   endproperty
   a_local_default: assert property (p_local_default)
      else $error("Local page state not at reset default");

   property p_bcc_read_default;
      @(posedge clock) disable iff (!resetn)
      firstCycle_r |-> rdSel_r[SRC_BCC0] == 1'b0
                       && rdSel_r[SRC_BCC1] == 1'b1;
   endproperty
   a_bcc_read_default: assert property (p_bcc_read_default)
      else $error("Back-channel read select not own port");

   property p_bcc_write_default;
      @(posedge clock) disable iff (!resetn)
      firstCycle_r |-> wrEn_r[SRC_BCC0] == 2'h1 && wrEn_r[SRC_BCC1] == 2'h2;
   endproperty
   a_bcc_write_default: assert property (p_bcc_write_default)
      else $error("Back-channel write enable not own port");

   property p_phys_port;
      @(posedge clock) disable iff (!resetn)
      req.rd && req.addr == ADDR_PORT_SEL |=>
         rdData_r[SEL_PHYS_BIT] == ($past(req.src) == SRC_BCC1);
   endproperty
   a_phys_port: assert property (p_phys_port)
      else $error("Physical port bit does not match access source");

   property p_embed_write;
      @(posedge clock) disable iff (!resetn)
      req.wr && req.addr == ADDR_EMBED && curWrEn[1] |=>
         embCtrl_r[1] == $past(req.wdata);
   endproperty
   a_embed_write: assert property (p_embed_write)
      else $error("Enabled port 1 missed embedded type write");

   property p_write_mask1;
      @(posedge clock) disable iff (!resetn)
      req.wr && req.addr == ADDR_EMBED && !curWrEn[1] |=>
         $stable(embCtrl_r[1]);
   endproperty
   a_write_mask1: assert property (p_write_mask1)
      else $error("Disabled port 1 block took a write");

   property p_embed_write0;
      @(posedge clock) disable iff (!resetn)
      req.wr && req.addr == ADDR_EMBED && curWrEn[0] |=>
         embCtrl_r[0] == $past(req.wdata);
   endproperty
   a_embed_write0: assert property (p_embed_write0)
      else $error("Enabled port 0 missed embedded type write");

   property p_broadcast;
      @(posedge clock) disable iff (!resetn)
      req.wr && isPaged(req.addr) && req.addr != ADDR_EMBED
         && curWrEn == 2'h3 |-> pagedWrEn == 2'h3;
   endproperty
   a_broadcast: assert property (p_broadcast)
      else $error("Broadcast write did not reach both port blocks");

   property p_no_stray_strobe;
      @(posedge clock) disable iff (!resetn)
      !req.wr |-> pagedWrEn == '0;
   endproperty
   a_no_stray_strobe: assert property (p_no_stray_strobe)
      else $error("Port write strobe without a write request");

   property p_read_answer;
      @(posedge clock) disable iff (!resetn)
      req.rd |=> rdValid_r;
   endproperty
   a_read_answer: assert property (p_read_answer)
      else $error("Read request not answered next cycle");

   property p_embed_read;
      @(posedge clock) disable iff (!resetn)
      req.rd && req.addr == ADDR_EMBED |=>
         rdData_r == ($past(curRdSel) ? $past(embCtrl_r[1])
                                      : $past(embCtrl_r[0]));
   endproperty
   a_embed_read: assert property (p_embed_read)
      else $error("Embedded type read from wrong port block");

   // Bits 7, 5 and 3:2 of the page select register always read zero
   property p_sel_reserved;
      @(posedge clock) disable iff (!resetn)
      req.rd && req.addr == ADDR_PORT_SEL |=>
         (rdData_r & 8'hAC) == READ_ZERO;
   endproperty
   a_sel_reserved: assert property (p_sel_reserved)
      else $error("Reserved page select bits read nonzero");

   property p_unpaged_read;
      @(posedge clock) disable iff (!resetn)
      req.rd && !isPaged(req.addr) && req.addr != ADDR_PORT_SEL |=>
         rdData_r == READ_ZERO;
   endproperty
   a_unpaged_read: assert property (p_unpaged_read)
      else $error("Unpaged read returned port block data");

   property p_bcc_isolation;
      @(posedge clock) disable iff (!resetn)
      req.wr && req.addr == ADDR_PORT_SEL && req.src == SRC_BCC1 |=>
         $stable(rdSel_r[SRC_LOCAL]) && $stable(wrEn_r[SRC_LOCAL])
         && $stable(rdSel_r[SRC_BCC0]) && $stable(wrEn_r[SRC_BCC0]);
   endproperty
   a_bcc_isolation: assert property (p_bcc_isolation)
      else $error("Back-channel page write disturbed another copy");

endmodule : rxpg_paging

// file: rxpg_pkg.sv
package rxpg_pkg;

   localparam int          NUM_PORTS     = 2;
   localparam int          NUM_SRC       = 3;

   // Access sources: local control bus, back channel of port 0 and port 1
   localparam logic [1:0]  SRC_LOCAL     = 2'h0;
   localparam logic [1:0]  SRC_BCC0      = 2'h1;
   localparam logic [1:0]  SRC_BCC1      = 2'h2;

   localparam logic [7:0]  ADDR_CAP      = 8'h4A;
   localparam logic [7:0]  ADDR_EMBED    = 8'h4B;
   localparam logic [7:0]  ADDR_PORT_SEL = 8'h4C;
   localparam logic [7:0]  PAGE_A_LO     = 8'h4D;
   localparam logic [7:0]  PAGE_A_HI     = 8'h7F;
   localparam logic [7:0]  PAGE_B_LO     = 8'hD0;
   localparam logic [7:0]  PAGE_B_HI     = 8'hDF;

   localparam int          SEL_WR0_BIT   = 0;
   localparam int          SEL_WR1_BIT   = 1;
   localparam int          SEL_RD_BIT    = 4;
   localparam int          SEL_PHYS_BIT  = 6;

   localparam int          EMB_EN_HI     = 7;
   localparam int          EMB_EN_LO     = 6;
   localparam int          EMB_ID_HI     = 5;
   localparam int          EMB_ID_LO     = 0;
   localparam logic [7:0]  EMB_RESET     = 8'h12;
   localparam logic [1:0]  EMB_EN_OFF    = 2'h0;

   localparam logic [7:0]  READ_ZERO     = 8'h00;
   localparam logic [1:0]  WR_NONE       = 2'h0;
   localparam logic [1:0]  PKT_CNT_MAX   = 2'h3;

   typedef struct packed {
      logic [1:0] src;
      logic [7:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } rxpg_req_t;

   typedef struct packed {
      logic       frameStart;
      logic       longPkt;
      logic       csiMode;
      logic [5:0] rawType;
   } rxpg_pkt_t;

   typedef struct packed {
      logic       valid;
      logic [5:0] dataType;
   } rxpg_dt_t;

endpackage : rxpg_pkg

// file: rxpg_embed_sub.sv
`timescale 1ns/10ps

module rxpg_embed_sub
   import rxpg_pkg::*;
(
   input  wire logic      clock,
   input  wire logic      resetn,
   input  wire logic [7:0] ctrl,
   input  wire rxpg_pkt_t pkt,
   output rxpg_dt_t       dtOut
);

   logic [1:0] pktCnt_r;
   logic [1:0] cntNow;
   logic [1:0] lineSel;
   logic       useEmbed;

   assign lineSel  = ctrl[EMB_EN_HI:EMB_EN_LO];
   // Frame start in the same cycle as a packet counts that packet as first
   assign cntNow   = pkt.frameStart ? 2'h0 : pktCnt_r;
   assign useEmbed = !pkt.csiMode && (cntNow < lineSel);

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         pktCnt_r <= 2'h0;
      end else if (pkt.longPkt) begin
         // Saturate: only the first three packets ever matter
         pktCnt_r <= (cntNow == PKT_CNT_MAX) ? PKT_CNT_MAX : cntNow + 2'h1;
      end else if (pkt.frameStart) begin
         pktCnt_r <= 2'h0;
      end
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         dtOut <= '0;
      end else begin
         dtOut.valid    <= pkt.longPkt;
         dtOut.dataType <= useEmbed ? ctrl[EMB_ID_HI:EMB_ID_LO]
                                    : pkt.rawType;
      end
   end

   property p_raw_passthrough;
      @(posedge clock) disable iff (!resetn)
      pkt.longPkt && (lineSel == EMB_EN_OFF) |=>
         dtOut.dataType == $past(pkt.rawType);
   endproperty
   a_raw_passthrough: assert property (p_raw_passthrough)
      else $error("Raw packet type altered while substitution off");

   property p_first_embedded;
      @(posedge clock) disable iff (!resetn)
      pkt.longPkt && pkt.frameStart && !pkt.csiMode && (lineSel != 2'h0) |=>
         dtOut.valid && dtOut.dataType == $past(ctrl[EMB_ID_HI:EMB_ID_LO]);
   endproperty
   a_first_embedded: assert property (p_first_embedded)
      else $error("First packet of frame not given embedded type");

   property p_csi_no_effect;
      @(posedge clock) disable iff (!resetn)
      pkt.longPkt && pkt.csiMode |=> dtOut.dataType == $past(pkt.rawType);
   endproperty
   a_csi_no_effect: assert property (p_csi_no_effect)
      else $error("Substitution applied in CSI receive mode");

   property p_count_restart;
      @(posedge clock) disable iff (!resetn)
      pkt.frameStart && !pkt.longPkt |=> pktCnt_r == 2'h0;
   endproperty
   a_count_restart: assert property (p_count_restart)
      else $error("Packet count not restarted at frame start");

endmodule : rxpg_embed_sub

// file: rxpg_port_model.sv
`timescale 1ns/10ps

// Stands in for the two receive-port register blocks behind the pager.
module rxpg_port_model
   import rxpg_pkg::*;
(
   input  wire logic                 clock,
   input  wire logic                 resetn,
   input  wire rxpg_req_t            req,
   input  wire logic [NUM_PORTS-1:0] wrEn,
   output logic [7:0]                rdata [NUM_PORTS]
);
   logic [7:0] mem_r [NUM_PORTS][256];

   // Each block takes only its own strobe, so a stray strobe shows on readback
   always_ff @(posedge clock or negedge resetn) begin
      for (int p = 0; p < NUM_PORTS; p++) begin
         for (int a = 0; a < 256; a++) begin
            if (!resetn) begin
               mem_r[p][a] <= 8'h00;
            end else if (wrEn[p] && req.wr && req.addr == 8'(a)) begin
               mem_r[p][a] <= req.wdata;
            end
         end
      end
   end

   always_comb begin
      for (int p = 0; p < NUM_PORTS; p++) begin
         rdata[p] = mem_r[p][req.addr];
      end
   end
endmodule : rxpg_port_model

// file: test_rxpg_paging.sv
`timescale 1ns/10ps

module test_rxpg_paging
   import rxpg_pkg::*;
   ;
   logic                 clock;
   logic                 resetn;
   rxpg_req_t            req;
   logic                 rdValid_r;
   logic [7:0]           rdData_r;
   logic [NUM_PORTS-1:0] pagedWrEn;
   logic [NUM_PORTS-1:0] lastWrEn;
   logic [7:0]           pagedRdata [NUM_PORTS];
   rxpg_pkt_t            pktIn      [NUM_PORTS];
   rxpg_dt_t             dtOut      [NUM_PORTS];
   logic [7:0]           embedCtrl  [NUM_PORTS];
   int                   errTotal;
   int                   testsRun;
   int                   cycles;
   logic [7:0]           addrTab [9];
   logic [1:0]           enTab   [9];
   logic [5:0]           exp0;

   rxpg_paging u_dut (
      .clock      (clock),
      .resetn     (resetn),
      .req        (req),
      .rdValid_r  (rdValid_r),
      .rdData_r   (rdData_r),
      .pagedWrEn  (pagedWrEn),
      .pagedRdata (pagedRdata),
      .pktIn      (pktIn),
      .dtOut      (dtOut),
      .embedCtrl  (embedCtrl)
   );

   rxpg_port_model u_model (
      .clock  (clock),
      .resetn (resetn),
      .req    (req),
      .wrEn   (pagedWrEn),
      .rdata  (pagedRdata)
   );

   task automatic stop_test;
      $display("checks %0d errors %0d", testsRun, errTotal);
      if (errTotal == 0 && testsRun > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : stop_test

   task automatic check(input string n, input logic [7:0] seen, exp);
      testsRun++;
      if (seen !== exp) begin
         errTotal++;
         $display("mismatch %s expected %h seen %h", n, exp, seen);
      end
   endtask : check

   // Strobe captured 1 ns after the request is driven at the falling edge, before the next rising edge
   task automatic wr(input logic [1:0] s, input logic [7:0] a, d);
      @(negedge clock);
      req = '{s, a, d, 1'b1, 1'b0};
      #1 lastWrEn = pagedWrEn;
      @(negedge clock);
      req.wr = 1'b0;
   endtask : wr

   task automatic rd(input logic [1:0] s, input logic [7:0] a, exp,
                     input string n);
      @(negedge clock);
      req = '{s, a, 8'h00, 1'b0, 1'b1};
      @(negedge clock);
      req.rd = 1'b0;
      check("rdValid", {7'h00, rdValid_r}, 8'h01);
      check(n, rdData_r, exp);
   endtask : rd

   task automatic pkt(input logic fs, input logic [5:0] e0);
      @(negedge clock);
      for (int p = 0; p < NUM_PORTS; p++) begin
         pktIn[p].longPkt = 1'b1;
         pktIn[p].frameStart = fs;
      end
      @(negedge clock);
      for (int p = 0; p < NUM_PORTS; p++) begin
         pktIn[p].longPkt = 1'b0;
         pktIn[p].frameStart = 1'b0;
         check("dtValid", {7'h00, dtOut[p].valid}, 8'h01);
      end
      check("dataType0", {2'h0, dtOut[0].dataType}, {2'h0, e0});
      check("dataType1", {2'h0, dtOut[1].dataType}, 8'h2C);
   endtask : pkt

   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end

   // Run needs about 120 cycles; the 5000-cycle ceiling leaves ample margin
   always @(posedge clock) begin
      cycles++;
      if (cycles == 5000) begin
         errTotal++;
         stop_test();
      end
   end

   initial begin
      resetn = 1'b0;
      req = '0;
      errTotal = 0;
      testsRun = 0;
      cycles = 0;
      pktIn[0] = '{1'b0, 1'b0, 1'b0, 6'h2B};
      pktIn[1] = '{1'b0, 1'b0, 1'b1, 6'h2C};
      addrTab = '{8'h4A, 8'h4D, 8'h7F, 8'h80, 8'hCF,
                  8'hD0, 8'hDF, 8'hE0, 8'h49};
      enTab = '{2'h3, 2'h3, 2'h3, 2'h0, 2'h0, 2'h3, 2'h3, 2'h0, 2'h0};
      repeat (4) @(negedge clock);
      resetn = 1'b1;
      rd(SRC_LOCAL, ADDR_PORT_SEL, 8'h00, "selLocal");
      rd(SRC_BCC0, ADDR_PORT_SEL, 8'h01, "selBcc0");
      rd(SRC_BCC1, ADDR_PORT_SEL, 8'h52, "selBcc1");
      rd(SRC_LOCAL, ADDR_EMBED, EMB_RESET, "embedReset");
      wr(SRC_LOCAL, 8'h50, 8'hEE);
      check("wrEnOff", {6'h00, lastWrEn}, 8'h00);
      wr(SRC_LOCAL, ADDR_PORT_SEL, 8'hFF);
      rd(SRC_LOCAL, ADDR_PORT_SEL, 8'h13, "selWrite");
      for (int i = 0; i < 9; i++) begin
         wr(SRC_LOCAL, addrTab[i], 8'hA5);
         check("pagedWrEn", {6'h00, lastWrEn}, {6'h00, enTab[i]});
      end
      wr(SRC_LOCAL, 8'h50, 8'hA5);
      wr(SRC_LOCAL, ADDR_PORT_SEL, 8'h01);
      wr(SRC_LOCAL, 8'h50, 8'h3C);
      rd(SRC_LOCAL, 8'h50, 8'h3C, "rdPort0");
      wr(SRC_LOCAL, ADDR_PORT_SEL, 8'h11);
      rd(SRC_LOCAL, 8'h50, 8'hA5, "rdPort1");
      rd(SRC_BCC0, ADDR_PORT_SEL, 8'h01, "bcc0Kept");
      rd(SRC_BCC0, 8'h50, 8'h3C, "bcc0Page");
      wr(SRC_BCC1, ADDR_PORT_SEL, 8'h00);
      rd(SRC_BCC1, ADDR_PORT_SEL, 8'h40, "bcc1Sel");
      rd(SRC_LOCAL, ADDR_PORT_SEL, 8'h11, "localKept");
      wr(SRC_LOCAL, ADDR_EMBED, 8'h6A);
      check("embed0", embedCtrl[0], 8'h6A);
      check("embed1", embedCtrl[1], EMB_RESET);
      rd(SRC_LOCAL, ADDR_EMBED, EMB_RESET, "embedRdSel");
      // Port 1 alone enabled: the port 0 copy must hold its value
      wr(SRC_BCC1, ADDR_PORT_SEL, 8'h02);
      wr(SRC_BCC1, ADDR_EMBED, 8'h55);
      check("embedBcc0", embedCtrl[0], 8'h6A);
      check("embedBcc1", embedCtrl[1], 8'h55);
      rd(2'h3, ADDR_PORT_SEL, 8'h11, "selSrc3");
      rd(SRC_LOCAL, 8'h80, 8'h00, "unpagedRd");
      wr(SRC_LOCAL, ADDR_PORT_SEL, 8'h03);
      // Each frame after the first restarts the count left saturated by the one before
      for (int en = 0; en < 4; en++) begin
         wr(SRC_LOCAL, ADDR_EMBED, {en[1:0], 6'h2A});
         for (int k = 0; k < 5; k++) begin
            exp0 = (k < en) ? 6'h2A : 6'h2B;
            pkt(k == 0, exp0);
         end
      end
      stop_test();
   end
endmodule : test_rxpg_paging
